// file: src/seis_top.sv
/*
  two-wire serial eeprom slave front end: conditions, address match,
  acknowledge, read shifting, write handoff and write-cycle busy timer.
  assumes the array side answers a read request within a few clocks and
  that the pad ring resolves the open-drain data line and the pull-downs.
*/
`default_nettype none

module seis_top
  import seis_pkg::*;
#(
  parameter int WR_CYC = WR_CYCLES,
  parameter int PU_CYC = PU_CYCLES
) (
  // clock and power-on reset
  input wire logic I_SYS_CLK,
  input wire logic I_RSTN,
  // two-wire bus pins
  input wire logic I_SCL,
  input wire logic I_SDA,
  output logic O_SDA,
  output logic O_SDA_OEN,
  // strap pins
  input wire logic I_SELECT_PIN_0,
  input wire logic I_SELECT_PIN_1,
  input wire logic I_SELECT_PIN_2,
  input wire logic I_WRITE_INHIBIT,
  // array side, read
  output logic O_RD_REQ,
  input wire logic [7:0] I_RD_DATA,
  // array side, write
  output logic O_WR_VALID,
  output logic O_WR_IS_ADDR,
  output logic [7:0] O_WR_DATA,
  output logic O_WR_START,
  // status
  output logic O_BUSY,
  output logic O_READY
);

  localparam logic [TMR_W-1:0] WR_LOAD = TMR_W'(WR_CYC);
  localparam logic [TMR_W-1:0] PU_LAST = TMR_W'(PU_CYC);

  seis_core_s q;
  seis_core_s next_q;
  logic [SYNC_W-1:0] pins;
  logic scl;
  logic sda;
  logic [2:0] sel;
  logic wp;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic byte_done;
  logic dev_match;

  // =========================================================
  // pin synchronisers; undriven straps arrive low from pad pull-downs
  seis_sync #(
    .W(SYNC_W)
  ) u_sync (
    .i_clk(I_SYS_CLK),
    .i_rstn(I_RSTN),
    .i_pin({I_SCL, I_SDA, I_SELECT_PIN_2, I_SELECT_PIN_1,
            I_SELECT_PIN_0, I_WRITE_INHIBIT}),
    .o_level(pins)
  );

  assign scl = pins[5];
  assign sda = pins[4];
  assign sel = pins[3:1]; // highest pin first
  assign wp = pins[0];

  // =========================================================
  // edges and bus conditions, only from filtered levels
  assign scl_rise = scl & ~q.scl_q;
  assign scl_fall = ~scl & q.scl_q;
  // data moving under a high clock is a condition, never data
  assign start_det = scl & q.scl_q & q.sda_q & ~sda;
  assign stop_det = scl & q.scl_q & ~q.sda_q & sda;
  assign byte_done = scl_fall && (q.cnt == 4'(BITS_PER_BYTE));
  assign dev_match = (q.sh[7:4] == PREAMBLE) && (q.sh[3:1] == sel);

  // =========================================================
  // next state
  always_comb begin
    next_q = q;
    next_q.scl_q = scl;
    next_q.sda_q = sda;
    next_q.rd_req = 1'b0;
    next_q.wr_start = 1'b0;
    next_q.wr.valid = 1'b0;
    next_q.sda_o = 1'b0; // open drain: the line is only ever pulled low

    // power-up delay, counts only after reset release
    if (!q.ready) begin
      next_q.pu_cnt = q.pu_cnt + 1'b1;
      if (q.pu_cnt == PU_LAST) begin
        next_q.ready = 1'b1;
      end
    end

    // write cycle timer, bounded by the load value
    if (q.busy_cnt != '0) begin
      next_q.busy_cnt = q.busy_cnt - 1'b1;
    end
    next_q.busy = (next_q.busy_cnt != '0);

    if (!q.ready) begin
      next_q.st = ST_IDLE;
    end else if (stop_det) begin
      // stop after accepted write data launches the cycle
      if (q.wr_pend) begin
        next_q.busy_cnt = WR_LOAD;
        next_q.busy = 1'b1;
        next_q.wr_start = 1'b1;
      end
      next_q.wr_pend = 1'b0;
      next_q.st = ST_IDLE;
      next_q.sda_oen = 1'b1;
    end else if (start_det) begin
      // repeated start also restarts the address phase
      next_q.st = ST_RECV;
      next_q.kind = KIND_DEV;
      next_q.cnt = CNT_RST;
      next_q.sda_oen = 1'b1;
    end else begin
      unique case (q.st)
        ST_IDLE: begin
          next_q.sda_oen = 1'b1; // nothing answered before a start
        end
        ST_RECV: begin
          if (scl_rise && (q.cnt != 4'(BITS_PER_BYTE))) begin
            next_q.sh = {q.sh[6:0], sda}; // capture on rising edge
            next_q.cnt = q.cnt + 1'b1;
          end else if (byte_done) begin
            next_q.cnt = CNT_RST;
            unique case (q.kind)
              KIND_DEV: begin
                // all eight bits in hand before deciding
                if (dev_match && !q.busy) begin
                  next_q.rw = q.sh[0]; // 1 read, 0 write
                  next_q.st = ST_SACK;
                  next_q.sda_oen = 1'b0;
                  next_q.rd_req = q.sh[0];
                end else begin
                  next_q.st = ST_IDLE;
                end
              end
              KIND_BADDR: begin
                next_q.st = ST_SACK;
                next_q.sda_oen = 1'b0;
                next_q.wr.valid = 1'b1;
                next_q.wr.is_addr = 1'b1;
                next_q.wr.data = q.sh;
              end
              KIND_DATA: begin
                if (q.wp_block) begin
                  next_q.st = ST_IDLE; // unacknowledged, write rejected
                end else begin
                  next_q.st = ST_SACK;
                  next_q.sda_oen = 1'b0;
                  next_q.wr.valid = 1'b1;
                  next_q.wr.is_addr = 1'b0;
                  next_q.wr.data = q.sh;
                  next_q.wr_pend = 1'b1;
                end
              end
              default: begin
                next_q.st = ST_IDLE;
              end
            endcase
          end
        end
        ST_SACK: begin
          // end of the ninth clock: release or start sending
          if (scl_fall) begin
            if (q.kind == KIND_DEV && q.rw) begin
              next_q.st = ST_SEND;
              next_q.sh = I_RD_DATA;
              next_q.cnt = CNT_RST;
              next_q.sda_oen = I_RD_DATA[7]; // one releases, zero pulls
            end else begin
              next_q.st = ST_RECV;
              next_q.sda_oen = 1'b1;
              if (q.kind == KIND_BADDR) begin
                // last falling edge before the first data byte
                next_q.wp_block = wp;
              end
              next_q.kind = (q.kind == KIND_DEV) ? KIND_BADDR : KIND_DATA;
            end
          end
        end
        ST_SEND: begin
          // outgoing bits change only after falling edges
          if (scl_fall) begin
            if (q.cnt == LAST_BIT) begin
              next_q.st = ST_MACK;
              next_q.sda_oen = 1'b1; // released for ninth clock
            end else begin
              next_q.cnt = q.cnt + 1'b1;
              next_q.sh = {q.sh[6:0], 1'b0};
              next_q.sda_oen = q.sh[6];
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            next_q.mack = ~sda;
            next_q.rd_req = ~sda; // fetch next byte only when acknowledged
          end else if (scl_fall) begin
            if (q.mack) begin
              next_q.st = ST_SEND;
              next_q.sh = I_RD_DATA;
              next_q.cnt = CNT_RST;
              next_q.sda_oen = I_RD_DATA[7];
            end else begin
              next_q.st = ST_IDLE; // no ack: wait for the closing stop
            end
          end
        end
        default: begin
          next_q.st = ST_IDLE;
        end
      endcase
    end
  end

  // =========================================================
  // state register; constants only under reset
  always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      q <= '0;
      q.st <= ST_IDLE;
      q.kind <= KIND_DEV;
      q.cnt <= CNT_RST;
      q.sh <= BYTE_RST;
      q.sda_oen <= 1'b1;
      q.scl_q <= 1'b1;
      q.sda_q <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  // =========================================================
  // outputs, all straight from the state register
  assign O_SDA = q.sda_o;
  assign O_SDA_OEN = q.sda_oen;
  assign O_RD_REQ = q.rd_req;
  assign O_WR_VALID = q.wr.valid;
  assign O_WR_IS_ADDR = q.wr.is_addr;
  assign O_WR_DATA = q.wr.data;
  assign O_WR_START = q.wr_start;
  assign O_BUSY = q.busy;
  assign O_READY = q.ready;

  // =========================================================
  // assertions
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RSTN);

  property p_start_recv;
    q.ready && start_det && !stop_det |=> q.st == ST_RECV && q.cnt == CNT_RST && q.kind == KIND_DEV;
  endproperty
  a_start_recv: assert property (p_start_recv) else $error("start not taken");

  property p_stop_idle;
    q.ready && stop_det |=> q.st == ST_IDLE && q.sda_oen;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop not taken");

  property p_idle_quiet;
    q.st == ST_IDLE |-> q.sda_oen && !q.rd_req;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("line driven while idle");

  property p_preamble;
    q.ready && !start_det && !stop_det && q.st == ST_RECV && q.kind == KIND_DEV && byte_done
      && q.sh[7:4] != PREAMBLE |=> q.st == ST_IDLE;
  endproperty
  a_preamble: assert property (p_preamble) else $error("foreign address answered");

  property p_busy_nack;
    q.ready && !start_det && !stop_det && q.st == ST_RECV && q.kind == KIND_DEV && byte_done
      && q.busy |=> q.st == ST_IDLE && q.sda_oen;
  endproperty
  a_busy_nack: assert property (p_busy_nack) else $error("address acked while busy");

  property p_ack_low;
    q.st == ST_SACK |-> !q.sda_oen;
  endproperty
  a_ack_low: assert property (p_ack_low) else $error("ack not driven");

  property p_mack_release;
    q.st == ST_MACK |-> q.sda_oen;
  endproperty
  a_mack_release: assert property (p_mack_release) else $error("ninth clock not released");

  property p_open_drain;
    1'b1 |-> O_SDA == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("line driven high");

  property p_wr_launch;
    q.ready && stop_det && q.wr_pend |=> q.wr_start && q.busy ##1 !q.wr_start;
  endproperty
  a_wr_launch: assert property (p_wr_launch) else $error("write cycle not launched");

  property p_wp_reject;
    q.ready && !start_det && !stop_det && q.st == ST_RECV && q.kind == KIND_DATA && byte_done
      && q.wp_block |=> q.st == ST_IDLE && !q.wr.valid;
  endproperty
  a_wp_reject: assert property (p_wp_reject) else $error("inhibited write accepted");

  property p_busy_bound;
    1'b1 |-> q.busy_cnt <= WR_LOAD;
  endproperty
  a_busy_bound: assert property (p_busy_bound) else $error("busy beyond write time");

  // bit timing on the shift register; a late capture would still pass the byte-level checks
  property p_capture_rise;
    q.ready && !start_det && !stop_det && q.st == ST_RECV && scl_rise && q.cnt != 4'(BITS_PER_BYTE)
      |=> q.sh[0] == $past(sda) && q.cnt == $past(q.cnt) + 4'h1;
  endproperty
  a_capture_rise: assert property (p_capture_rise) else $error("bit not taken on rising clock");

  property p_send_hold;
    q.ready && !start_det && !stop_det && q.st == ST_SEND && !scl_fall |=> $stable(q.sda_oen);
  endproperty
  a_send_hold: assert property (p_send_hold) else $error("read bit moved without falling clock");

  property p_read_first;
    q.ready && !start_det && !stop_det && q.st == ST_SACK && q.kind == KIND_DEV && q.rw && scl_fall
      |=> q.st == ST_SEND && q.sda_oen == $past(I_RD_DATA[7]);
  endproperty
  a_read_first: assert property (p_read_first) else $error("first read bit wrong");

  property p_baddr_ack;
    q.ready && !start_det && !stop_det && q.st == ST_RECV && q.kind == KIND_BADDR && byte_done
      |=> q.st == ST_SACK && !q.sda_oen && q.wr.valid && q.wr.is_addr;
  endproperty
  a_baddr_ack: assert property (p_baddr_ack) else $error("byte address not acknowledged");

  c_addr_ack: cover property (q.st == ST_RECV ##1 q.st == ST_SACK);
  c_data_wr: cover property (q.wr.valid && !q.wr.is_addr);
  c_read_byte: cover property (q.st == ST_SEND ##1 q.st == ST_MACK);
  c_launch: cover property (q.wr_start);

endmodule // seis_top

`default_nettype wire

// file: src/seis_pkg.sv
/*
  constants, types and state record of the two-wire eeprom slave front end.
  assumes a 50 MHz system clock and an asynchronous active-low power-on reset.
*/
`default_nettype none

package seis_pkg;

  // ==========================================================
  // timing
  localparam int SYS_CLK_HZ = 50_000_000;
  localparam int T_WR_MS = 5;   // write cycle, longest
  localparam int T_PU_MS = 1;   // power-up to ready, longest
  localparam int WR_CYCLES = SYS_CLK_HZ / 1000 * T_WR_MS;
  localparam int PU_CYCLES = SYS_CLK_HZ / 1000 * T_PU_MS;
  localparam int TMR_W = 18;

  // ==========================================================
  // address byte layout
  localparam logic [3:0] PREAMBLE = 4'hA;
  localparam int BITS_PER_BYTE = 8;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] CNT_RST = 4'h0;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam int SYNC_W = 6;

  // ==========================================================
  // types
  typedef enum logic [2:0] {
    ST_IDLE, ST_RECV, ST_SACK, ST_SEND, ST_MACK
  } seis_state_e;

  typedef enum logic [1:0] {
    KIND_DEV, KIND_BADDR, KIND_DATA
  } seis_kind_e;

  // write handoff to the array side
  typedef struct packed {
    logic valid;
    logic is_addr;
    logic [7:0] data;
  } seis_wr_s;

  typedef struct packed {
    seis_state_e st;
    seis_kind_e kind;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic scl_q;
    logic sda_q;
    logic rw;
    logic mack;
    logic wp_block;
    logic wr_pend;
    logic [TMR_W-1:0] busy_cnt;
    logic [TMR_W-1:0] pu_cnt;
    logic ready;
    logic busy;
    logic sda_oen;
    logic sda_o;
    logic rd_req;
    logic wr_start;
    seis_wr_s wr;
  } seis_core_s;

endpackage

`default_nettype wire

// file: src/seis_sync.sv
/*
  three-stage input synchroniser with agreement filter.
  assumes asynchronous pins; output moves only when stages two and three agree.
*/
`default_nettype none

module seis_sync
  import seis_pkg::*;
#(
  parameter int W = 1
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // pins in, filtered level out
  input wire logic [W-1:0] i_pin,
  output logic [W-1:0] o_level
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } seis_sync_s;

  seis_sync_s q;
  seis_sync_s next_q;

  // =========================================================
  // shift chain; s1 feeds s2 only
  always_comb begin
    next_q = q;
    next_q.s1 = i_pin;
    next_q.s2 = q.s1;
    next_q.s3 = q.s2;
    for (int i = 0; i < W; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        next_q.lvl[i] = q.s3[i]; // one-sample glitches never reach lvl
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign o_level = q.lvl;

endmodule // seis_sync

`default_nettype wire

// file: tb/seis_master.sv
/*
  two-wire bus master model: clock, conditions and bytes.
  assumes the bench resolves the data line with a pull-up.
*/
`default_nettype none

module seis_master (
  // link clock and resolved data line
  input wire logic i_lclk,
  input wire logic i_sda,
  // bus clock, and pull on the data line
  output logic o_scl,
  output logic o_sda_pull
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // bus idles released, clock high
  initial begin
    o_scl = 1'b1;
    o_sda_pull = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_lclk);
  endtask

  // data moves only while the clock is low, so no stray condition
  task automatic clock_low();
    o_scl <= 1'b0;
    tick(1);
  endtask

  task automatic start_cond();
    o_sda_pull <= 1'b0;
    tick(1);
    o_scl <= 1'b1;
    tick(2);
    o_sda_pull <= 1'b1;
    tick(2);
    clock_low();
  endtask

  task automatic stop_cond();
    o_sda_pull <= 1'b1;
    tick(1);
    o_scl <= 1'b1;
    tick(2);
    o_sda_pull <= 1'b0;
    tick(2);
  endtask

  // one bit: zero pulls, one releases; sampled late in the high phase
  task automatic bit_xfer(input logic b, output logic r);
    o_sda_pull <= !b;
    tick(1);
    o_scl <= 1'b1;
    tick(2);
    r = i_sda;
    clock_low();
  endtask

  // eight bits msb first, then the acknowledge clock
  task automatic byte_xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack_out);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(d[i], r);
      q[i] = r;
    end
    bit_xfer(ack_in, ack_out);
  endtask
endmodule // seis_master

`default_nettype wire

// file: tb/seis_top_tb.sv
/*
  self-checking bench of the two-wire eeprom slave front end.
  assumes a pulled-up bus; the array side is modelled here.
*/
`default_nettype none

module seis_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WR_T = 2000;
  localparam int PU_T = 50;

  logic sys_clk, rstn, lclk, scl, pull, sda, inhibit, o_sda, o_oen, o_rd_req;
  logic o_wr_valid, o_wr_is_addr, o_wr_start, o_busy, o_ready;
  logic [2:0] sel;
  logic [7:0] rd_data, o_wr_data, nb;
  logic [7:0] rd_q[$];
  logic [8:0] wr_q[$];
  int wst = 0;
  int error_cnt = 0;
  int comparisons = 0;

  // ==========================================================
  // clocks; the link clock has an unrelated phase
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  initial begin
    lclk = 1'b0;
    #7;
    forever #80 lclk = ~lclk;
  end

  // open-drain line with pull-up
  assign sda = !(pull || (!o_oen && !o_sda));

  seis_top #(.WR_CYC(WR_T), .PU_CYC(PU_T)) i_seis_top (
    .I_SYS_CLK(sys_clk), .I_RSTN(rstn), .I_SCL(scl), .I_SDA(sda), .O_SDA(o_sda), .O_SDA_OEN(o_oen),
    .I_SELECT_PIN_0(sel[0]), .I_SELECT_PIN_1(sel[1]), .I_SELECT_PIN_2(sel[2]), .I_WRITE_INHIBIT(inhibit),
    .O_RD_REQ(o_rd_req), .I_RD_DATA(rd_data), .O_WR_VALID(o_wr_valid), .O_WR_IS_ADDR(o_wr_is_addr),
    .O_WR_DATA(o_wr_data), .O_WR_START(o_wr_start), .O_BUSY(o_busy), .O_READY(o_ready));

  seis_master i_seis_master (.i_lclk(lclk), .i_sda(sda), .o_scl(scl), .o_sda_pull(pull));

  // array side: fresh random byte per request, writes logged
  always @(posedge sys_clk) begin
    if (o_rd_req === 1'b1) begin
      nb = 8'($urandom);
      rd_data <= nb;
      rd_q.push_back(nb);
    end
    if (o_wr_valid === 1'b1) wr_q.push_back({o_wr_is_addr, o_wr_data});
    if (o_wr_start === 1'b1) wst++;
  end

  // ==========================================================
  // checking and closing
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  function automatic logic [7:0] me(input logic rw);
    return {4'hA, sel, rw};
  endfunction

  // start plus address byte; ack level expected on the line
  task automatic adr(input logic [7:0] a, input logic exp);
    logic [7:0] q;
    logic ack;
    i_seis_master.start_cond();
    i_seis_master.byte_xfer(a, 1'b1, q, ack);
    check(ack, exp);
  endtask

  task automatic wrb(input logic [7:0] d, input logic exp);
    logic [7:0] q;
    logic ack;
    i_seis_master.byte_xfer(d, 1'b1, q, ack);
    check(ack, exp);
  endtask

  // bounded wait for the write cycle to end
  task automatic wait_idle();
    for (int n = 0; n < WR_T + 20 && o_busy !== 1'b0; n++) @(negedge sys_clk);
    check(o_busy, 1'b0);
    if (o_busy !== 1'b0) complete_run();
  endtask

  // bounded wait for the power-up delay after any reset release
  task automatic wait_ready();
    int n;
    for (n = 0; n < PU_T + 20 && o_ready !== 1'b1; n++) @(negedge sys_clk);
    check(16'(n >= PU_T), 16'h1);
    check(o_ready, 1'b1);
    if (o_ready !== 1'b1) complete_run();
  endtask

  initial begin
    #1ms;
    check(16'h0, 16'h1);
    complete_run();
  end

  // ==========================================================
  // main sequence
  initial begin
    logic [7:0] q, ba, d;
    logic ack;
    logic [8:0] exp_q[$];
    int n, w0;
    void'($urandom(32'hfa30));
    rstn = 1'b0;
    sel = 3'h0;
    inhibit = 1'b0;
    rd_data = 8'h00;
    repeat (4) @(posedge sys_clk);
    check(o_oen, 1'b1);
    check(o_ready, 1'b0);
    rstn <= 1'b1;
    wait_ready();
    // bits with no start before them are ignored
    i_seis_master.clock_low();
    i_seis_master.byte_xfer(me(1'b0), 1'b1, q, ack);
    check(ack, 1'b1);
    i_seis_master.stop_cond();
    repeat (4) begin
      d = 8'($urandom);
      if (d[7:1] == {4'hA, sel}) d[7] = 1'b0;
      adr(d, 1'b1);
      i_seis_master.stop_cond();
    end
    for (int s = 0; s < 8; s++) begin
      @(posedge sys_clk);
      sel <= 3'(s);
      adr({4'hA, 3'(s), 1'b0}, 1'b0);
      i_seis_master.stop_cond();
    end
    check(16'(wst), 16'h0);
    repeat (2) begin
      @(posedge sys_clk);
      sel <= 3'($urandom);
      @(posedge sys_clk);
      wr_q.delete();
      w0 = wst;
      ba = 8'($urandom);
      exp_q = {{1'b1, ba}};
      adr(me(1'b0), 1'b0);
      wrb(ba, 1'b0);
      repeat (1 + $urandom % 4) begin
        d = 8'($urandom);
        exp_q.push_back({1'b0, d});
        wrb(d, 1'b0);
      end
      i_seis_master.stop_cond();
      check(16'(wr_q.size()), 16'(exp_q.size()));
      foreach (exp_q[k]) check(wr_q[k], exp_q[k]);
      check(16'(wst - w0), 16'h1);
      check(o_busy, 1'b1);
      adr(me(1'b0), 1'b1);
      i_seis_master.stop_cond();
      wait_idle();
    end
    // selective read through a repeated start
    rd_q.delete();
    adr(me(1'b0), 1'b0);
    wrb(8'($urandom), 1'b0);
    adr(me(1'b1), 1'b0);
    check(o_sda, 1'b0);
    check(o_oen, rd_q[0][7]);
    n = 2 + $urandom % 3;
    for (int k = 0; k < n; k++) begin
      i_seis_master.byte_xfer(8'hFF, 1'(k == n - 1), q, ack);
      check(q, rd_q.pop_front());
    end
    check(ack, 1'b1);
    i_seis_master.stop_cond();
    check(16'(rd_q.size()), 16'h0);
    check(o_busy, 1'b0);
    // inhibited write: data refused, no write cycle
    @(posedge sys_clk);
    inhibit <= 1'b1;
    w0 = wst;
    adr(me(1'b0), 1'b0);
    wrb(8'($urandom), 1'b0);
    wrb(8'($urandom), 1'b1);
    i_seis_master.stop_cond();
    check(16'(wst - w0), 16'h0);
    check(o_busy, 1'b0);
    // supply dip mid-run: reset re-entered, then the block must answer again
    @(posedge sys_clk);
    rstn <= 1'b0;
    inhibit <= 1'b0;
    repeat (2) @(posedge sys_clk);
    check(o_ready, 1'b0);
    check(o_oen, 1'b1);
    rstn <= 1'b1;
    wait_ready();
    adr(me(1'b0), 1'b0);
    i_seis_master.stop_cond();
    check(16'(wst - w0), 16'h0);
    complete_run();
  end
endmodule // seis_top_tb

`default_nettype wire
